// ### dbmi_assertions.sv
// Link protocol checks between the requester and the device end
`timescale 1ns/1ps
module dbmi_assertions
    import dbmi_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [3:0] req_ftype,
    input wire logic [3:0] req_ttype,
    input wire logic [3:0] req_size,
    input wire logic [7:0] req_tid,
    input wire logic [15:0] req_info,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [3:0] rsp_ftype,
    input wire logic [3:0] rsp_ttype,
    input wire logic [3:0] rsp_status,
    input wire logic [7:0] rsp_tid,
    input wire logic rsp_has_data
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Decoded request kinds at the handshake
    logic take, mnt, pw, dbl;
    assign take = req_valid && req_ready;
    assign mnt = take && req_ftype == DBMI_FTYPE_MAINT;
    assign pw = mnt && req_ttype == DBMI_TT_PORT_WR;
    assign dbl = take && req_ftype == DBMI_FTYPE_DBELL;

    AST_ANSWER_ALL: assert property (
        take && !pw |=> rsp_valid && rsp_tid == $past(req_tid))
        else $error("request not answered with its tid");
    AST_PW_SILENT: assert property (pw |=> !rsp_valid)
        else $error("port-write was answered");
    AST_RD_FORMAT: assert property (
        mnt && req_ttype == DBMI_TT_RD_REQ && req_size == DBMI_SIZE_WORD
        |=> rsp_ftype == DBMI_FTYPE_MAINT && rsp_ttype == DBMI_TT_RD_RSP
        && rsp_has_data) else $error("bad read response format");
    AST_WR_FORMAT: assert property (
        mnt && req_ttype == DBMI_TT_WR_REQ |=> rsp_ftype == DBMI_FTYPE_MAINT
        && rsp_ttype == DBMI_TT_WR_RSP && !rsp_has_data)
        else $error("bad write response format");
    AST_SIZE_ERR: assert property (
        mnt && !pw && req_size != DBMI_SIZE_WORD
        |=> rsp_status == DBMI_ST_ERROR) else $error("non-word not refused");
    AST_DB_FORMAT: assert property (
        dbl |=> rsp_ftype == DBMI_FTYPE_RESP && !rsp_has_data)
        else $error("bad doorbell response format");
    AST_DB_RSV: assert property (
        dbl && (req_info & DBMI_INFO_RSV_MASK) != 16'h0000
        |=> rsp_status == DBMI_ST_ERROR) else $error("reserved info accepted");
    AST_ONE_OUT: assert property (rsp_valid |-> !req_ready)
        else $error("request accepted while response pending");
    AST_RSP_CAUSE: assert property ($rose(rsp_valid) |-> $past(take))
        else $error("response without request");
    AST_RSP_HOLD: assert property (
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_status)
        && $stable(rsp_tid)) else $error("response dropped before accept");
    // Main outcomes seen on the link
    cover property (dbl ##1 rsp_status == DBMI_ST_DONE);
    cover property (dbl ##1 rsp_status == DBMI_ST_RETRY);
    cover property (dbl ##1 rsp_status == DBMI_ST_ERROR);
    cover property (pw);
endmodule

// ### dbmi_device.sv
// Device end: maintenance register access and doorbell status setting
`timescale 1ns/1ps
// Notes on behaviour
// - Maintenance responses reuse the maintenance format
// - Data only in write requests, read responses
// - Configuration accesses are single whole words
// - Payload never exceeds the write size
// - Answer every maintenance read and write
// - Port-writes never answered, may be dropped
// - Doorbell has info only, gets response
// - Info field selects exactly one status bit
// - Four 16-bit status registers, 64 sources
// - Info bits 6:5 register, 3:0 bit
// - Each status bit has 4-bit routing nibble
// - Reserved info bits give error, no set
// - Already set bit gives retry, unchanged
module dbmi_device
    import dbmi_pkg::*;
#(
    parameter int NCORE = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    dbmi_link_if.device link,
    input wire logic [DBMI_NREG*DBMI_NBIT-1:0] clear_bits,
    output logic [NCORE-1:0] core_irq,
    output logic [DBMI_NREG*DBMI_NBIT-1:0] status_bits,
    output logic [31:0] port_write_data,
    output logic port_write_valid,
    input wire logic port_write_ready
);
    // Doorbell sources across all status registers
    localparam int NSRC = DBMI_NREG * DBMI_NBIT;

    // Whole device state; two routing words per status register
    typedef struct packed {
        logic [NSRC-1:0] status;
        logic [DBMI_NREG-1:0][1:0][31:0] route;
        logic rsp_valid;
        logic [3:0] rsp_ftype;
        logic [3:0] rsp_ttype;
        logic [3:0] rsp_status;
        logic [7:0] rsp_tid;
        logic [31:0] rsp_data;
        logic rsp_has_data;
        logic [31:0] pw_data;
        logic pw_valid;
    } dbmi_dev_state_t;

    dbmi_dev_state_t s_q;
    dbmi_dev_state_t s_d;

    // Flat index of a status bit from register and bit number
    function automatic logic [5:0] dbmi_src_idx(input logic [1:0] r,
                                                input logic [3:0] b);
        dbmi_src_idx = {r, b};
    endfunction

    // Routing nibble of one source
    function automatic logic [3:0] dbmi_route_of(
        input dbmi_dev_state_t st, input logic [5:0] idx);
        logic [31:0] w;
        logic [2:0] nib;
        w = st.route[idx[5:4]][idx[3]];
        nib = idx[2:0];
        dbmi_route_of = w[nib*4 +: 4];
    endfunction

    // A request is taken on the edge where valid meets ready
    logic take;
    assign take = link.req_valid && link.req_ready;
    // One answer at most in flight; holding ready low keeps a second
    // request from overwriting the response still waiting
    assign link.req_ready = !s_q.rsp_valid;

    // Next-state logic for responses, status and routing
    always_comb begin
        logic [1:0] reg_sel;
        logic [3:0] bit_sel;
        logic [5:0] idx;
        logic [1:0] creg;
        reg_sel = link.req_info[DBMI_INFO_REG_MSB:DBMI_INFO_REG_LSB];
        bit_sel = link.req_info[DBMI_INFO_BIT_MSB:0];
        idx = dbmi_src_idx(reg_sel, bit_sel);
        creg = link.req_offset[3:2];
        s_d = s_q;
        // Software clears; a same-cycle doorbell set wins below
        s_d.status = s_q.status & ~clear_bits;
        if (s_q.rsp_valid && link.rsp_ready) begin
            s_d.rsp_valid = 1'b0;
        end
        if (s_q.pw_valid && port_write_ready) begin
            s_d.pw_valid = 1'b0;
        end
        // Maintenance: reads and writes answered, port-writes queued
        if (take && link.req_ftype == DBMI_FTYPE_MAINT) begin
            s_d.rsp_ftype = DBMI_FTYPE_MAINT;
            s_d.rsp_tid = link.req_tid;
            s_d.rsp_data = 32'h0000_0000;
            s_d.rsp_has_data = 1'b0;
            s_d.rsp_status = DBMI_ST_DONE;
            if (link.req_ttype == DBMI_TT_PORT_WR) begin
                // No response; dropped if queue still busy
                if (!s_q.pw_valid) begin
                    s_d.pw_data = link.req_data;
                    s_d.pw_valid = 1'b1;
                end
            end else if (link.req_ttype == DBMI_TT_RD_REQ) begin
                s_d.rsp_valid = 1'b1;
                s_d.rsp_ttype = DBMI_TT_RD_RSP;
                if (link.req_size != DBMI_SIZE_WORD) begin
                    // Narrow or wide reads are answered, never performed
                    s_d.rsp_status = DBMI_ST_ERROR;
                end else begin
                    s_d.rsp_has_data = 1'b1;
                    // Unmapped offsets read back as zero
                    if (link.req_offset[7:4] == DBMI_CFG_STATUS[7:4]) begin
                        s_d.rsp_data = {16'h0000,
                            s_q.status[creg*DBMI_NBIT +: DBMI_NBIT]};
                    end else if (link.req_offset[7:4] ==
                                 DBMI_CFG_ROUTE_LO[7:4]) begin
                        s_d.rsp_data = s_q.route[creg][0];
                    end else if (link.req_offset[7:4] ==
                                 DBMI_CFG_ROUTE_HI[7:4]) begin
                        s_d.rsp_data = s_q.route[creg][1];
                    end
                end
            end else if (link.req_ttype == DBMI_TT_WR_REQ) begin
                s_d.rsp_valid = 1'b1;
                s_d.rsp_ttype = DBMI_TT_WR_RSP;
                if (link.req_size != DBMI_SIZE_WORD) begin
                    s_d.rsp_status = DBMI_ST_ERROR;
                end else if (link.req_offset[7:4] ==
                             DBMI_CFG_ROUTE_LO[7:4]) begin
                    s_d.route[creg][0] = link.req_data;
                end else if (link.req_offset[7:4] ==
                             DBMI_CFG_ROUTE_HI[7:4]) begin
                    s_d.route[creg][1] = link.req_data;
                end else if (link.req_offset[7:4] ==
                             DBMI_CFG_CLEAR[7:4]) begin
                    s_d.status[creg*DBMI_NBIT +: DBMI_NBIT] =
                        s_d.status[creg*DBMI_NBIT +: DBMI_NBIT] &
                        ~link.req_data[15:0];
                end
            end else begin
                // Unknown maintenance code: refused with an error
                s_d.rsp_valid = 1'b1;
                s_d.rsp_ttype = DBMI_TT_WR_RSP;
                s_d.rsp_status = DBMI_ST_ERROR;
            end
        end else if (take && link.req_ftype == DBMI_FTYPE_DBELL) begin
            // Doorbell: reserved bits first, then the busy bit
            s_d.rsp_valid = 1'b1;
            s_d.rsp_ftype = DBMI_FTYPE_RESP;
            s_d.rsp_ttype = 4'h0;
            s_d.rsp_tid = link.req_tid;
            s_d.rsp_data = 32'h0000_0000;
            s_d.rsp_has_data = 1'b0;
            if ((link.req_info & DBMI_INFO_RSV_MASK) != 16'h0000) begin
                s_d.rsp_status = DBMI_ST_ERROR;
            end else if (s_q.status[idx]) begin
                s_d.rsp_status = DBMI_ST_RETRY;
                s_d.status[idx] = 1'b1;
            end else begin
                s_d.status[idx] = 1'b1;
                s_d.rsp_status = DBMI_ST_DONE;
            end
        end else if (take) begin
            // Unknown kinds are refused, never silently dropped
            s_d.rsp_valid = 1'b1;
            s_d.rsp_ftype = DBMI_FTYPE_RESP;
            s_d.rsp_ttype = 4'h0;
            s_d.rsp_tid = link.req_tid;
            s_d.rsp_status = DBMI_ST_ERROR;
            s_d.rsp_has_data = 1'b0;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Pending interrupt per core from routed status bits
    always_comb begin
        core_irq = '0;
        for (int i = 0; i < NSRC; i++) begin
            logic [3:0] c;
            c = dbmi_route_of(s_q, 6'(i));
            // Routes naming an absent core raise nothing
            if (s_q.status[i] && 32'(c) < NCORE) begin
                core_irq[c[1:0]] = 1'b1;
            end
        end
    end

    // Outputs straight from the state register
    assign status_bits = s_q.status;
    assign port_write_data = s_q.pw_data;
    assign port_write_valid = s_q.pw_valid;
    assign link.rsp_valid = s_q.rsp_valid;
    assign link.rsp_ftype = s_q.rsp_ftype;
    assign link.rsp_ttype = s_q.rsp_ttype;
    assign link.rsp_status = s_q.rsp_status;
    assign link.rsp_tid = s_q.rsp_tid;
    assign link.rsp_data = s_q.rsp_data;
    assign link.rsp_has_data = s_q.rsp_has_data;
endmodule

// ### dbmi_link_if.sv
// Link between the remote requester and the inbound device end
`timescale 1ns/1ps
interface dbmi_link_if;
    logic req_valid;
    logic req_ready;
    logic [3:0] req_ftype;
    logic [3:0] req_ttype;
    logic [3:0] req_size;
    logic [7:0] req_tid;
    logic [15:0] req_info;
    logic [7:0] req_offset;
    logic [31:0] req_data;
    logic rsp_valid;
    logic rsp_ready;
    logic [3:0] rsp_ftype;
    logic [3:0] rsp_ttype;
    logic [3:0] rsp_status;
    logic [7:0] rsp_tid;
    logic [31:0] rsp_data;
    logic rsp_has_data;
    modport device (
        input req_valid, req_ftype, req_ttype, req_size, req_tid,
        input req_info, req_offset, req_data, rsp_ready,
        output req_ready, rsp_valid, rsp_ftype, rsp_ttype, rsp_status,
        output rsp_tid, rsp_data, rsp_has_data
    );
    modport remote (
        output req_valid, req_ftype, req_ttype, req_size, req_tid,
        output req_info, req_offset, req_data, rsp_ready,
        input req_ready, rsp_valid, rsp_ftype, rsp_ttype, rsp_status,
        input rsp_tid, rsp_data, rsp_has_data
    );
endinterface

// ### dbmi_pkg.sv
// Shared constants for the maintenance and doorbell inbound path
package dbmi_pkg;
    // Transaction types on the link
    localparam logic [3:0] DBMI_FTYPE_MAINT = 4'h8;
    localparam logic [3:0] DBMI_FTYPE_DBELL = 4'hA;
    localparam logic [3:0] DBMI_FTYPE_RESP = 4'hD;
    // Maintenance transaction codes
    localparam logic [3:0] DBMI_TT_RD_REQ = 4'h0;
    localparam logic [3:0] DBMI_TT_WR_REQ = 4'h1;
    localparam logic [3:0] DBMI_TT_RD_RSP = 4'h2;
    localparam logic [3:0] DBMI_TT_WR_RSP = 4'h3;
    localparam logic [3:0] DBMI_TT_PORT_WR = 4'h4;
    // Response status codes
    localparam logic [3:0] DBMI_ST_DONE = 4'h0;
    localparam logic [3:0] DBMI_ST_RETRY = 4'h3;
    localparam logic [3:0] DBMI_ST_ERROR = 4'h7;
    // Word-size code carried in maintenance requests
    localparam logic [3:0] DBMI_SIZE_WORD = 4'h4;
    // Doorbell info field layout
    localparam int DBMI_INFO_REG_LSB = 5;
    localparam int DBMI_INFO_REG_MSB = 6;
    localparam int DBMI_INFO_BIT_MSB = 3;
    localparam logic [15:0] DBMI_INFO_RSV_MASK = 16'hFF90;
    // Status and routing geometry
    localparam int DBMI_NREG = 4;
    localparam int DBMI_NBIT = 16;
    localparam int DBMI_ROUTE_W = 4;
    localparam int DBMI_BITS_PER_RR = 8;
    localparam logic [15:0] DBMI_STATUS_RST = 16'h0000;
    localparam logic [31:0] DBMI_ROUTE_RST = 32'h0000_0000;
    // Host AHB register offsets
    localparam logic [7:0] DBMI_A_CTRL = 8'h00;
    localparam logic [7:0] DBMI_A_HDR = 8'h04;
    localparam logic [7:0] DBMI_A_DATA = 8'h08;
    localparam logic [7:0] DBMI_A_STAT = 8'h0C;
    localparam logic [7:0] DBMI_A_RDATA = 8'h10;
    // Configuration word offset of status and routing registers
    localparam logic [7:0] DBMI_CFG_STATUS = 8'h00;
    localparam logic [7:0] DBMI_CFG_ROUTE_LO = 8'h10;
    localparam logic [7:0] DBMI_CFG_ROUTE_HI = 8'h20;
    localparam logic [7:0] DBMI_CFG_CLEAR = 8'h30;
endpackage

// ### dbmi_remote.sv
// Remote end: AHB-Lite controlled requester for maintenance and doorbells
`timescale 1ns/1ps
module dbmi_remote
    import dbmi_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    dbmi_link_if.remote link
);
    typedef enum {DBMI_IDLE, DBMI_SEND, DBMI_WAIT} dbmi_rst_t;
    typedef struct packed {
        dbmi_rst_t st;
        logic [31:0] hdr;
        logic [31:0] data;
        logic [31:0] rdata;
        logic [3:0] rstatus;
        logic done;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
    } dbmi_rem_state_t;

    dbmi_rem_state_t s_q;
    dbmi_rem_state_t s_d;

    logic carry_data;
    // Doorbells and read requests travel without payload
    assign carry_data = s_q.hdr[31:28] == DBMI_FTYPE_MAINT &&
                        (s_q.hdr[27:24] == DBMI_TT_WR_REQ ||
                         s_q.hdr[27:24] == DBMI_TT_PORT_WR);

    logic need_rsp;
    // Port-writes expect no answer
    assign need_rsp = !(s_q.hdr[31:28] == DBMI_FTYPE_MAINT &&
                        s_q.hdr[27:24] == DBMI_TT_PORT_WR);

    // Bus decode, request launch and answer capture
    always_comb begin
        logic go;
        go = 1'b0;
        s_d = s_q;
        if (s_q.wr_pend) begin
            s_d.wr_pend = 1'b0;
            if (s_q.wr_addr == DBMI_A_HDR) begin
                s_d.hdr = hwdata;
            end else if (s_q.wr_addr == DBMI_A_DATA) begin
                s_d.data = hwdata;
            end else if (s_q.wr_addr == DBMI_A_CTRL) begin
                go = hwdata[0];
            end
        end
        if (hsel && hready && htrans[1]) begin
            if (hwrite) begin
                s_d.wr_pend = 1'b1;
                s_d.wr_addr = haddr;
            end else if (haddr == DBMI_A_HDR) begin
                s_d.hrdata = s_q.hdr;
            end else if (haddr == DBMI_A_DATA) begin
                s_d.hrdata = s_q.data;
            end else if (haddr == DBMI_A_STAT) begin
                s_d.hrdata = {24'h000000, s_q.rstatus, 1'b0,
                              s_q.st != DBMI_IDLE, 1'b0, s_q.done};
            end else if (haddr == DBMI_A_RDATA) begin
                s_d.hrdata = s_q.rdata;
            end else begin
                s_d.hrdata = 32'h0000_0000;
            end
        end
        case (s_q.st)
            DBMI_IDLE: begin
                if (go) begin
                    s_d.st = DBMI_SEND;
                    s_d.done = 1'b0;
                end
            end
            DBMI_SEND: begin
                if (link.req_ready) begin
                    s_d.st = need_rsp ? DBMI_WAIT : DBMI_IDLE;
                    s_d.done = !need_rsp;
                end
            end
            DBMI_WAIT: begin
                if (link.rsp_valid) begin
                    s_d.st = DBMI_IDLE;
                    s_d.done = 1'b1;
                    s_d.rstatus = link.rsp_status;
                    s_d.rdata = link.rsp_has_data ? link.rsp_data
                                                  : 32'h0000_0000;
                end
            end
            default: s_d.st = DBMI_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata = s_q.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign link.req_valid = (s_q.st == DBMI_SEND);
    assign link.req_ftype = s_q.hdr[31:28];
    assign link.req_ttype = s_q.hdr[27:24];
    // Maintenance always word sized
    assign link.req_size = DBMI_SIZE_WORD;
    assign link.req_tid = s_q.hdr[23:16];
    assign link.req_info = s_q.hdr[15:0];
    assign link.req_offset = s_q.hdr[7:0];
    // Payload only on maintenance writes and port-writes
    assign link.req_data = carry_data ? s_q.data : 32'h0000_0000;
    assign link.rsp_ready = (s_q.st == DBMI_WAIT);
endmodule

// ### doorbell_maint_inbound_tb.sv
// Testbench driving the requester over AHB-Lite against the device end
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    failures++; $display("Error %s expected %h seen %h", nm, e, g); end end
module doorbell_maint_inbound_tb
    import dbmi_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [7:0] haddr, transfer_info_descriptor;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, port_write_data;
    logic [63:0] clear_bits, status_bits, sb;
    logic [3:0] core_irq;
    logic port_write_valid, port_write_ready;
    int failures, comparisons;
    logic [15:0] tab [8] = '{16'h0000, 16'h0009, 16'h0027, 16'h002C,
        16'h0045, 16'h004F, 16'h0066, 16'h006B};
    logic [15:0] rsv [3] = '{16'h0010, 16'h0080, 16'h8000};
    // Flat status bit expected for each decode example
    int pos [8] = '{0, 9, 23, 28, 37, 47, 54, 59};

    dbmi_link_if link();
    dbmi_device dbmi_device_inst (.hclk(hclk), .hresetn(hresetn), .link(link),
        .clear_bits(clear_bits), .core_irq(core_irq),
        .status_bits(status_bits), .port_write_data(port_write_data),
        .port_write_valid(port_write_valid),
        .port_write_ready(port_write_ready));
    dbmi_remote dbmi_remote_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(link));
    dbmi_assertions dbmi_assertions_inst (.hclk(hclk), .hresetn(hresetn),
        .req_valid(link.req_valid), .req_ready(link.req_ready),
        .req_ftype(link.req_ftype), .req_ttype(link.req_ttype),
        .req_size(link.req_size), .req_tid(link.req_tid),
        .req_info(link.req_info), .rsp_valid(link.rsp_valid),
        .rsp_ready(link.rsp_ready), .rsp_ftype(link.rsp_ftype),
        .rsp_ttype(link.rsp_ttype), .rsp_status(link.rsp_status),
        .rsp_tid(link.rsp_tid), .rsp_has_data(link.rsp_has_data));

    // Clock and watchdog
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        stop_test();
    end

    task automatic stop_test();
        $display("Counts: %0d comparisons, %0d failures", comparisons,
            failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One single AHB transfer; hready is waited on, never assumed
    task automatic ahb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Send one request and check the returned status code
    task automatic op(input logic [3:0] f, input logic [3:0] t,
        input logic [15:0] i, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] r;
        int n;
        transfer_info_descriptor = transfer_info_descriptor + 8'h01;
        ahb(1'b1, DBMI_A_DATA, d, r);
        ahb(1'b1, DBMI_A_HDR, {f, t, transfer_info_descriptor, i}, r);
        ahb(1'b1, DBMI_A_CTRL, 32'h0000_0001, r);
        n = 0;
        while (link.rsp_valid !== 1'b1 && n < 50) begin
            @(negedge hclk);
            n++;
        end
        `CHK("response", 1'b1, link.rsp_valid)
        r = 32'h0000_0000;
        while (!(r[0] === 1'b1 && r[2] === 1'b0) && n < 80) begin
            ahb(1'b0, DBMI_A_STAT, 32'h0000_0000, r);
            n++;
        end
        `CHK("status code", st, r[7:4])
    endtask

    task automatic mwr(input logic [7:0] off, input logic [31:0] d);
        op(DBMI_FTYPE_MAINT, DBMI_TT_WR_REQ, {8'h00, off}, d,
            DBMI_ST_DONE);
    endtask

    task automatic mrd(input logic [7:0] off, input logic [31:0] e);
        logic [31:0] r;
        op(DBMI_FTYPE_MAINT, DBMI_TT_RD_REQ, {8'h00, off}, 32'h0,
            DBMI_ST_DONE);
        ahb(1'b0, DBMI_A_RDATA, 32'h0000_0000, r);
        `CHK("read data", e, r)
        `CHK("bus okay", 2'b10, {hreadyout, hresp})
    endtask

    // Launch one port-write through the requester, then let it settle
    task automatic pwr(input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, DBMI_A_DATA, d, r);
        ahb(1'b1, DBMI_A_HDR,
            {DBMI_FTYPE_MAINT, DBMI_TT_PORT_WR, 24'h0}, r);
        ahb(1'b1, DBMI_A_CTRL, 32'h0000_0001, r);
        repeat (6) @(negedge hclk);
    endtask

    initial begin
        {hsel, hwrite, port_write_ready} = 3'h0;
        {haddr, transfer_info_descriptor} = 16'h0000;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        clear_bits = 64'h0;
        failures = 0;
        comparisons = 0;
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        // First doorbell sets its bit and signals core 0
        op(DBMI_FTYPE_DBELL, 4'h0, 16'h0027, 32'h0, DBMI_ST_DONE);
        `CHK("bit 23", 1'b1, status_bits[23])
        `CHK("irq", 4'h1, core_irq)
        op(DBMI_FTYPE_DBELL, 4'h0, 16'h0027, 32'h0, DBMI_ST_RETRY);
        `CHK("bit 23 kept", 64'h0080_0000, status_bits)
        $display("test doorbell done");
        // Reroute bit 23 to core 1, then clear it
        mwr(DBMI_CFG_ROUTE_LO + 8'h04, 32'h1000_0000);
        `CHK("irq routed", 4'h2, core_irq)
        mrd(DBMI_CFG_ROUTE_LO + 8'h04, 32'h1000_0000);
        @(posedge hclk);
        clear_bits <= 64'h0080_0000;
        @(posedge hclk);
        clear_bits <= 64'h0;
        @(negedge hclk);
        `CHK("cleared", 64'h0, status_bits)
        `CHK("irq off", 4'h0, core_irq)
        $display("test routing done");
        // Reserved info bits are refused and change nothing
        foreach (rsv[k]) begin
            sb = status_bits;
            op(DBMI_FTYPE_DBELL, 4'h0, rsv[k], 32'h0, DBMI_ST_ERROR);
            `CHK("no set", sb, status_bits)
        end
        // Unknown transaction kinds are refused and set nothing
        op(4'h5, 4'h0, 16'h0000, 32'h0, DBMI_ST_ERROR);
        op(DBMI_FTYPE_MAINT, 4'h7, 16'h0000, 32'h0, DBMI_ST_ERROR);
        `CHK("no set kinds", sb, status_bits)
        $display("test reserved done");
        // Every decode example from register 0 to register 3
        foreach (tab[k]) begin
            op(DBMI_FTYPE_DBELL, 4'h0, tab[k], 32'h0, DBMI_ST_DONE);
            `CHK("bit", 1'b1, status_bits[pos[k]])
        end
        `CHK("all bits", 64'h0840_8020_1080_0201, status_bits)
        mrd(DBMI_CFG_STATUS + 8'h04, 32'h0000_1080);
        mwr(DBMI_CFG_ROUTE_HI, 32'h0000_0030);
        `CHK("irq mix", 4'hB, core_irq)
        mwr(DBMI_CFG_CLEAR + 8'h04, 32'h0000_FFFF);
        mrd(DBMI_CFG_STATUS + 8'h04, 32'h0000_0000);
        $display("test decode done");
        // Port-write is queued with no answer; a second one is dropped
        pwr(32'hA5A5_0001);
        `CHK("pw valid", 1'b1, port_write_valid)
        `CHK("pw data", 32'hA5A5_0001, port_write_data)
        `CHK("pw silent", 1'b0, link.rsp_valid)
        pwr(32'hA5A5_0002);
        `CHK("pw dropped", 32'hA5A5_0001, port_write_data)
        `CHK("pw still", 1'b1, port_write_valid)
        `CHK("pw silent 2", 1'b0, link.rsp_valid)
        @(posedge hclk);
        port_write_ready <= 1'b1;
        repeat (2) @(negedge hclk);
        `CHK("pw taken", 1'b0, port_write_valid)
        $display("test port-write done");
        stop_test();
    end
endmodule
